/* hdl/srr_defs.svh */
// constants of the stream receive output routing block
// Overview of operation
// - bit 15 sends channel B to port B unless bit 14 is set
// - bit 14 sends channel B to port A
// - bit 7 sends channel A to port B unless bit 6 is set
// - bit 6 sends channel A to port A
// - bit 11 strips channel B satellite header
// - bit 3 strips channel A satellite header
// - bit 10 low rejects video, flags error
// - bit 9 low rejects satellite, flags error
// - bit 8 low rejects transport; resets high
// - unknown formats always flag format error
// - bit 2 picks 6.144 or 3.072 MHz clock
// - bit 0 merges both channels into one
// - bit 1 picks port of merged stream
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SRR_OFS_CFG   8'h1c
`define SRR_OFS_STS   8'h40
`define SRR_OFS_MSK   8'h44
`define SRR_OFS_HDR_A 8'h48
`define SRR_OFS_HDR_B 8'h4c
`define SRR_OFS_ISO_A 8'h50
`define SRR_OFS_CIP_A 8'h54
`define SRR_OFS_ISO_B 8'h58
`define SRR_OFS_CIP_B 8'h5c

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define SRR_CHB_PB    15
`define SRR_CHB_PA    14
`define SRR_CHB_STRIP 11
`define SRR_VID_EN    10
`define SRR_SAT_EN    9
`define SRR_TS_EN     8
`define SRR_CHA_PB    7
`define SRR_CHA_PA    6
`define SRR_CHA_STRIP 3
`define SRR_RATE      2
`define SRR_MSEL      1
`define SRR_MERGE     0
`define SRR_CFG_W     16
`define SRR_CFG_RESET 16'h0100
`define SRR_CFG_WMASK 16'hcfcf
`define SRR_IRQ_W     2

// ----------------------------------------------------------------
// timing and packet sizes
// ----------------------------------------------------------------
`define SRR_SYS_KHZ   125000
`define SRR_FAST_KHZ  6144
`define SRR_SLOW_KHZ  3072
`define SRR_NCO_W     24
`define SRR_PKT_FULL  140
`define SRR_PKT_STRIP 130
`define SRR_HDR_BYTES (`SRR_PKT_FULL - `SRR_PKT_STRIP)

`endif

/* hdl/srr_pkg.sv */
// types of the stream receive output routing block
`include "srr_defs.svh"
package srr_pkg;

    typedef enum logic [1:0] {
        SRR_FMT_VIDEO,
        SRR_FMT_SAT,
        SRR_FMT_TS,
        SRR_FMT_OTHER
    } srr_fmt_t;

    typedef enum logic [1:0] {
        SRR_IDLE,
        SRR_PASS,
        SRR_DROP
    } srr_cst_t;

    typedef struct packed {
        logic        valid;
        logic        sop;
        logic        eop;
        srr_fmt_t    fmt;
        logic [7:0]  data;
        logic [31:0] iso_hdr;
        logic [31:0] cip_hdr;
    } srr_rx_t;

    typedef struct packed {
        logic       valid;
        logic       sop;
        logic       eop;
        logic [7:0] data;
    } srr_byte_t;

    typedef struct packed {
        srr_cst_t    st;
        logic        strip;
        logic        first;
        logic        ack;
        logic        err;
        logic [3:0]  cnt;
        logic [31:0] hdr;
        logic [31:0] iso;
        logic [31:0] cip;
    } srr_chan_st_t;

    typedef struct packed {
        logic [`SRR_CFG_W-1:0] cfg;
        logic [`SRR_IRQ_W-1:0] sts;
        logic [`SRR_IRQ_W-1:0] msk;
        logic                  irq;
        logic [31:0]           rdata;
        logic                  rdy;
        logic                  resp;
        logic                  wr;
        logic [7:0]            waddr;
        logic [`SRR_NCO_W-1:0] acc;
        logic                  sclk;
        srr_byte_t [1:0]       port;
        logic [1:0]            lock;
        logic [1:0]            owner;
        logic [1:0]            last;
    } srr_top_st_t;

endpackage

/* hdl/srr_chan.sv */
// per-channel format filter and header stripper
`timescale 1ns/1ns
`include "srr_defs.svh"
module srr_chan (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    // settings
    input  wire logic             vid_en,
    input  wire logic             sat_en,
    input  wire logic             ts_en,
    input  wire logic             strip,
    // receive side
    input  wire srr_pkg::srr_rx_t rx,
    output logic                  rx_ready,
    // bytes towards the router
    output srr_pkg::srr_byte_t    out,
    input  wire logic             out_ready,
    // status
    output logic                  fmt_err,
    output logic [31:0]           hdr,
    output logic [31:0]           iso,
    output logic [31:0]           cip
);
    import srr_pkg::*;

    localparam logic [3:0] HDR_N = 4'(`SRR_HDR_BYTES);

    srr_chan_st_t s;
    srr_chan_st_t next_s;
    logic         sop_ok;
    logic         pass;
    logic         strip_on;
    logic         hdr_byte;
    logic         take;
    logic [3:0]   cnt_now;

    always_comb begin
        next_s = s;
        next_s.err = 1'b0;
        case (rx.fmt)
            SRR_FMT_VIDEO: sop_ok = vid_en;
            SRR_FMT_SAT:   sop_ok = sat_en;
            SRR_FMT_TS:    sop_ok = ts_en;
            default:       sop_ok = 1'b0;
        endcase
        pass     = rx.sop ? sop_ok : (s.st == SRR_PASS);
        strip_on = rx.sop ? (strip && rx.fmt == SRR_FMT_SAT) : s.strip;
        cnt_now  = rx.sop ? 4'h0 : s.cnt;
        hdr_byte = strip_on && (cnt_now < HDR_N);
        out.valid = rx.valid && !s.ack && pass && !hdr_byte;
        out.sop   = rx.sop ? !strip_on : s.first;
        out.eop   = rx.eop;
        out.data  = rx.data;
        // ack blocks a second take of the byte the source still holds
        take = rx.valid && !s.ack && (!pass || hdr_byte || out_ready);
        next_s.ack = take;
        if (take) begin
            if (rx.sop) begin
                next_s.st    = sop_ok ? SRR_PASS : SRR_DROP;
                next_s.strip = strip_on;
                next_s.err   = !sop_ok;
                if (!sop_ok) begin
                    next_s.iso = rx.iso_hdr;
                    next_s.cip = rx.cip_hdr;
                end
            end
            next_s.first = hdr_byte && (cnt_now == HDR_N - 4'h1);
            next_s.cnt   = hdr_byte ? cnt_now + 4'h1 : cnt_now;
            // only the leading four header bytes are kept
            if (hdr_byte && cnt_now < 4'h4) begin
                next_s.hdr = {s.hdr[23:0], rx.data};
            end
            if (rx.eop) begin
                next_s.st = SRR_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rx_ready = s.ack;
    assign fmt_err  = s.err;
    assign hdr      = s.hdr;
    assign iso      = s.iso;
    assign cip      = s.cip;

    sequence rejected_s;
        take && rx.sop && !sop_ok;
    endsequence

    reject_flag_a:
        assert property (@(posedge ref_clk) disable iff (!rstn)
            rejected_s |=> fmt_err ##1 !fmt_err || $past(take))
        else $error("rejected packet gave no single error pulse");
    drop_quiet_a:
        assert property (@(posedge ref_clk) disable iff (!rstn)
            s.st == SRR_DROP && !rx.sop |-> !out.valid)
        else $error("rejected packet leaked a byte");
    strip_len_a:
        assert property (@(posedge ref_clk) disable iff (!rstn)
            out.valid && out.sop && strip_on |-> cnt_now == HDR_N)
        else $error("stripped packet started at wrong byte");
endmodule

/* hdl/srr_top.sv */
// stream receive output routing: registers, router and output ports
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "srr_defs.svh"
module srr_top (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    // ahb-lite register slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // interrupt
    output logic                  irq,
    // receive channels
    input  wire srr_pkg::srr_rx_t rx_a,
    input  wire srr_pkg::srr_rx_t rx_b,
    output logic                  rx_a_ready,
    output logic                  rx_b_ready,
    // stream processor ports
    output logic                  stream_out_clock,
    output srr_pkg::srr_byte_t    port_a,
    output srr_pkg::srr_byte_t    port_b
);
    import srr_pkg::*;

    // ----------------------------------------------------------------
    // output byte clock increments
    // ----------------------------------------------------------------
    // phase accumulator: 125 MHz does not divide to 6.144 MHz, so the
    // period dithers by one system cycle around the exact mean
    localparam logic [`SRR_NCO_W-1:0] INC_FAST = `SRR_NCO_W'(
        (64'(`SRR_FAST_KHZ) << `SRR_NCO_W) / 64'(`SRR_SYS_KHZ));
    localparam logic [`SRR_NCO_W-1:0] INC_SLOW = `SRR_NCO_W'(
        (64'(`SRR_SLOW_KHZ) << `SRR_NCO_W) / 64'(`SRR_SYS_KHZ));

    srr_top_st_t           s;
    srr_top_st_t           next_s;
    srr_rx_t   [1:0]       rx_v;
    srr_byte_t [1:0]       co;
    logic      [1:0]       cready;
    logic      [1:0]       cack;
    logic      [1:0]       err;
    logic      [1:0]       strip_v;
    logic      [31:0]      hdr_v [2];
    logic      [31:0]      iso_v [2];
    logic      [31:0]      cip_v [2];
    logic      [1:0][1:0]  allow;
    logic      [1:0][1:0]  grant;
    logic      [1:0]       va;
    logic                  pick;
    logic                  avail;
    logic                  merge;
    logic                  msel;
    logic                  tick;
    logic                  acc_ok;
    logic [`SRR_NCO_W-1:0] inc;
    logic [`SRR_NCO_W-1:0] acc_nxt;
    logic [`SRR_IRQ_W-1:0] clr;
    logic [31:0]           rd;

    assign rx_v    = {rx_b, rx_a};
    assign strip_v = {s.cfg[`SRR_CHB_STRIP], s.cfg[`SRR_CHA_STRIP]};

    // ----------------------------------------------------------------
    // receive channels
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_chan
        srr_chan u_chan (
            .ref_clk   (ref_clk),
            .rstn      (rstn),
            .vid_en    (s.cfg[`SRR_VID_EN]),
            .sat_en    (s.cfg[`SRR_SAT_EN]),
            .ts_en     (s.cfg[`SRR_TS_EN]),
            .strip     (strip_v[c]),
            .rx        (rx_v[c]),
            .rx_ready  (cack[c]),
            .out       (co[c]),
            .out_ready (cready[c]),
            .fmt_err   (err[c]),
            .hdr       (hdr_v[c]),
            .iso       (iso_v[c]),
            .cip       (cip_v[c])
        );
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        va     = 2'h0;
        pick   = 1'b0;
        avail  = 1'b0;
        grant  = '0;
        clr    = '0;
        rd     = 32'h0;
        merge  = s.cfg[`SRR_MERGE];
        msel   = s.cfg[`SRR_MSEL];

        // index [port][channel]; a channel set to both ports goes to A
        allow[0][0] = s.cfg[`SRR_CHA_PA];
        allow[0][1] = s.cfg[`SRR_CHB_PA];
        allow[1][0] = s.cfg[`SRR_CHA_PB] && !allow[0][0];
        allow[1][1] = s.cfg[`SRR_CHB_PB] && !allow[0][1];
        if (merge) begin
            allow[0] = {!msel, !msel};
            allow[1] = {msel, msel};
        end

        // byte clock
        inc = s.cfg[`SRR_RATE] ? INC_SLOW : INC_FAST;
        acc_nxt = s.acc + inc;
        next_s.acc  = acc_nxt;
        next_s.sclk = acc_nxt[`SRR_NCO_W-1];
        // bytes launch on the falling clock edge, sampled on the rising
        tick = s.sclk && !acc_nxt[`SRR_NCO_W-1];

        // port arbitration, whole packets only
        for (int p = 0; p < 2; p++) begin
            va[0] = allow[p][0] && co[0].valid && co[0].sop;
            va[1] = allow[p][1] && co[1].valid && co[1].sop;
            if (s.lock[p]) begin
                pick  = s.owner[p];
                avail = co[pick].valid;
            end else begin
                pick  = (&va) ? !s.last[p] : va[1];
                avail = |va;
            end
            if (tick) begin
                grant[p][pick] = avail;
                next_s.port[p] = avail ? co[pick] : '0;
                if (avail) begin
                    next_s.lock[p]  = !co[pick].eop;
                    next_s.owner[p] = pick;
                    if (co[pick].eop) begin
                        next_s.last[p] = pick;
                    end
                end
            end
        end
        // a channel routed nowhere is drained and lost
        for (int c = 0; c < 2; c++) begin
            cready[c] = grant[0][c] || grant[1][c]
                        || !(allow[0][c] || allow[1][c]);
        end

        // register bus, zero wait states
        acc_ok = hsel && htrans[1] && hready;
        case (haddr[7:0])
            `SRR_OFS_CFG:   rd = 32'(s.cfg);
            `SRR_OFS_STS:   rd = 32'(s.sts);
            `SRR_OFS_MSK:   rd = 32'(s.msk);
            `SRR_OFS_HDR_A: rd = hdr_v[0];
            `SRR_OFS_HDR_B: rd = hdr_v[1];
            `SRR_OFS_ISO_A: rd = iso_v[0];
            `SRR_OFS_CIP_A: rd = cip_v[0];
            `SRR_OFS_ISO_B: rd = iso_v[1];
            `SRR_OFS_CIP_B: rd = cip_v[1];
            default:        rd = 32'h0;
        endcase
        if (acc_ok && !hwrite) begin
            next_s.rdata = rd;
        end
        next_s.wr    = acc_ok && hwrite && hsize == 3'h2;
        next_s.waddr = haddr[7:0];
        next_s.rdy   = 1'b1;
        next_s.resp  = 1'b0;
        if (s.wr) begin
            case (s.waddr)
                `SRR_OFS_CFG: begin
                    next_s.cfg = hwdata[`SRR_CFG_W-1:0]
                                 & `SRR_CFG_WMASK;
                end
                `SRR_OFS_STS: clr = hwdata[`SRR_IRQ_W-1:0];
                `SRR_OFS_MSK: next_s.msk = hwdata[`SRR_IRQ_W-1:0];
                default: ;
            endcase
        end
        // a new error wins over a clear in the same cycle
        next_s.sts = (s.sts & ~clr) | err;
        next_s.irq = |(next_s.sts & next_s.msk);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s     <= '0;
            s.cfg <= `SRR_CFG_RESET;
            s.rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata           = s.rdata;
    assign hreadyout        = s.rdy;
    assign hresp            = s.resp;
    assign irq              = s.irq;
    assign rx_a_ready       = cack[0];
    assign rx_b_ready       = cack[1];
    assign stream_out_clock = s.sclk;
    assign port_a           = s.port[0];
    assign port_b           = s.port[1];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [7:0] gap;
    logic       seen;
    logic       chg;
    logic       rate_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gap    <= 8'h0;
            seen   <= 1'b0;
            chg    <= 1'b0;
            rate_q <= 1'b0;
        end else begin
            rate_q <= s.cfg[`SRR_RATE];
            gap    <= tick ? 8'h1 : gap + 8'h1;
            if (tick) begin
                seen <= 1'b1;
                chg  <= 1'b0;
            end else if (rate_q != s.cfg[`SRR_RATE]) begin
                chg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence cfg_wr_s;
        hsel && htrans[1] && hready && hwrite && hsize == 3'h2
        && haddr[7:0] == `SRR_OFS_CFG;
    endsequence

    sequence byte_out_s(p, c);
        tick && grant[p][c];
    endsequence

    cfg_reset_a:
        assert property (disable iff (1'b0)
            !rstn |=> s.cfg == `SRR_CFG_RESET)
        else $error("configuration reset value wrong");
    cfg_write_a:
        assert property (cfg_wr_s ##1 1'b1
            |=> s.cfg == ($past(hwdata[15:0]) & `SRR_CFG_WMASK))
        else $error("configuration write not stored");
    rsvd_zero_a:
        assert property ($past(hsel && htrans[1] && hready && !hwrite
            && haddr[7:0] == `SRR_OFS_CFG)
            |-> hrdata[13:12] == 2'h0 && hrdata[5:4] == 2'h0)
        else $error("reserved configuration bits read nonzero");
    irq_level_a:
        assert property (err != 2'h0 |=> (s.sts & $past(err)) != 2'h0
            && irq == |(s.sts & s.msk))
        else $error("format error not latched or signalled");
    route_pa_a:
        assert property (grant[0] != 2'h0 |-> (merge ? !msel
            : (grant[0][0] ? s.cfg[`SRR_CHA_PA] : s.cfg[`SRR_CHB_PA])))
        else $error("port A took an unrouted channel");
    route_pb_a:
        assert property (grant[1] != 2'h0 |-> (merge ? msel
            : (grant[1][0] ? s.cfg[`SRR_CHA_PB] : s.cfg[`SRR_CHB_PB])))
        else $error("port B took an unrouted channel");
    port_data_a:
        assert property (byte_out_s(0, 0) |=> port_a.valid
            && port_a.data == $past(co[0].data) && !stream_out_clock)
        else $error("port A byte not launched on clock fall");
    merge_port_a:
        assert property (merge && !msel |-> grant[1] == 2'h0)
        else $error("merged stream leaked to port B");
    whole_pkt_a:
        assert property (s.lock[0] && !(tick && co[s.owner[0]].eop)
            |=> s.lock[0] && s.owner[0] == $past(s.owner[0]))
        else $error("port A switched channel inside a packet");
    clk_rate_a:
        assert property (tick && seen && !chg
            && rate_q == s.cfg[`SRR_RATE]
            |-> (s.cfg[`SRR_RATE] ? (gap >= 8'h28 && gap <= 8'h29)
                                  : (gap >= 8'h14 && gap <= 8'h15)))
        else $error("output byte clock period wrong");
endmodule

/* dv/srr_tsp_model.sv */
// behavioural stream processor that watches both output ports
`timescale 1ns/1ns
module srr_tsp_model
(
    // byte clock and ports from the block
    input  wire logic                stream_out_clock,
    input  wire srr_pkg::srr_byte_t  port_a,
    input  wire srr_pkg::srr_byte_t  port_b,
    // what was seen
    output int                       cnt_a,
    output int                       cnt_b,
    output logic [7:0]               first_a,
    output logic [7:0]               first_b,
    output int                       split
);
    import srr_pkg::*;

    logic open_a = 1'h0;
    logic open_b = 1'h0;

    // sample mid-byte: ports only move when the byte clock falls
    always @(posedge stream_out_clock) begin
        if (port_a.valid === 1'h1) begin
            cnt_a <= cnt_a + 1;
            if (port_a.sop) begin
                first_a <= port_a.data;
                if (open_a) split <= split + 1;
            end
            open_a <= port_a.eop ? 1'h0 : (port_a.sop ? 1'h1 : open_a);
        end
        if (port_b.valid === 1'h1) begin
            cnt_b <= cnt_b + 1;
            if (port_b.sop) begin
                first_b <= port_b.data;
                if (open_b) split <= split + 1;
            end
            open_b <= port_b.eop ? 1'h0 : (port_b.sop ? 1'h1 : open_b);
        end
    end
endmodule

/* dv/tb_top.sv */
// self-checking bench for the stream receive output routing block
`timescale 1ns/1ns
`include "srr_defs.svh"
module tb_top;
    import srr_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        ref_clk = 1'h0;
    logic        rstn = 1'h0;
    logic        hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    srr_rx_t     rx_a = '0;
    srr_rx_t     rx_b = '0;
    logic        rx_a_ready;
    logic        rx_b_ready;
    logic        stream_out_clock;
    srr_byte_t   port_a;
    srr_byte_t   port_b;
    int          cnt_a;
    int          cnt_b;
    logic [7:0]  first_a;
    logic [7:0]  first_b;
    int          split;
    int          bad_count = 0;
    int          check_count = 0;
    int          cyc_n = 0;
    int          gap = 0;
    int          gcnt = 0;
    logic        sclk_q = 1'h0;
    logic [7:0]  nb = 8'h10;

    srr_top u_srr_top (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .rx_a(rx_a),
        .rx_b(rx_b), .rx_a_ready(rx_a_ready), .rx_b_ready(rx_b_ready),
        .stream_out_clock(stream_out_clock), .port_a(port_a),
        .port_b(port_b));

    srr_tsp_model u_srr_tsp_model (.stream_out_clock(stream_out_clock),
        .port_a(port_a), .port_b(port_b), .cnt_a(cnt_a), .cnt_b(cnt_b),
        .first_a(first_a), .first_b(first_b), .split(split));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // byte clock period and hang guard
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        sclk_q <= stream_out_clock;
        if (sclk_q === 1'h1 && stream_out_clock === 1'h0) begin
            gap  <= gcnt;
            gcnt <= 1;
        end else gcnt <= gcnt + 1;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        hsel   <= 1'h1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        ahb(1'h1, a, d, r);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        ahb(1'h0, a, 32'h0, r);
    endtask

    // one packet, byte i carries b+i; a released line shows the inverse
    task automatic send(input logic ch, input srr_fmt_t f, input int n,
                        input logic [7:0] b);
        srr_rx_t x;
        for (int i = 0; i < n; i++) begin
            x = {1'h1, i == 0, i == n - 1, f, b + 8'(i),
                 {24'h15a5c3, b}, {24'hea5a3c, b}};
            if (ch) rx_b <= x;
            else rx_a <= x;
            do @(posedge ref_clk);
            while ((ch ? rx_b_ready : rx_a_ready) !== 1'h1);
        end
        x.valid = 1'h0;
        x.data  = ~x.data;
        if (ch) rx_b <= x;
        else rx_a <= x;
    endtask

    // k bytes expected on port p; none means a rejected packet
    task automatic run(input logic [15:0] c, input logic ch,
                       input srr_fmt_t f, input int n, input logic p,
                       input int k);
        int          c0;
        int          c1;
        logic [7:0]  b;
        logic [31:0] r;
        b  = nb;
        nb = nb + 8'h10;
        wr(`SRR_OFS_STS, 32'h3);
        wr(`SRR_OFS_CFG, {16'h0, c});
        c0 = cnt_a;
        c1 = cnt_b;
        send(ch, f, n, b);
        repeat (60) @(posedge ref_clk);
        chk(cnt_a - c0, p ? 0 : k);
        chk(cnt_b - c1, p ? k : 0);
        if (k > 0) chk(p ? first_b : first_a, b + n - k);
        rd(`SRR_OFS_STS, r);
        chk(r, k > 0 ? 32'h0 : (ch ? 32'h2 : 32'h1));
        if (k == 0) begin
            rd(ch ? `SRR_OFS_ISO_B : `SRR_OFS_ISO_A, r);
            chk(r, {24'h15a5c3, b});
            rd(ch ? `SRR_OFS_CIP_B : `SRR_OFS_CIP_A, r);
            chk(r, {24'hea5a3c, b});
        end
        if (k > 0 && n > k) begin
            rd(ch ? `SRR_OFS_HDR_B : `SRR_OFS_HDR_A, r);
            chk(r, {b, b + 8'h1, b + 8'h2, b + 8'h3});
        end
    endtask

    task automatic t_regs();
        logic [31:0] r;
        rd(`SRR_OFS_CFG, r);
        chk(r, 32'h0100);
        chk(irq, 1'h0);
        chk(hresp, 1'h0);
        wr(`SRR_OFS_CFG, 32'hffff3f3f);
        rd(`SRR_OFS_CFG, r);
        chk(r, 32'h0f0f);
        wr(32'h80, 32'h1234);
        rd(32'h80, r);
        chk(r, 32'h0);
    endtask

    task automatic t_clock();
        wr(`SRR_OFS_CFG, 32'h0100);
        repeat (100) @(posedge ref_clk);
        chk(gap >= 20 && gap <= 21, 32'h1);
        wr(`SRR_OFS_CFG, 32'h0104);
        repeat (100) @(posedge ref_clk);
        chk(gap >= 40 && gap <= 41, 32'h1);
    endtask

    task automatic t_irq();
        wr(`SRR_OFS_MSK, 32'h1);
        run(16'h0040, 1'h0, SRR_FMT_TS, 3, 1'h0, 0);
        chk(irq, 1'h1);
        wr(`SRR_OFS_STS, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'h0);
        wr(`SRR_OFS_MSK, 32'h0);
        run(16'h0040, 1'h0, SRR_FMT_SAT, 3, 1'h0, 0);
        chk(irq, 1'h0);
    endtask

    // both channels at once must reach the merged port whole
    task automatic t_merge();
        int c0;
        int s0;
        wr(`SRR_OFS_CFG, 32'h0101);
        c0 = cnt_a;
        s0 = split;
        fork
            send(1'h0, SRR_FMT_TS, 3, 8'h20);
            send(1'h1, SRR_FMT_TS, 3, 8'h30);
        join
        repeat (200) @(posedge ref_clk);
        chk(cnt_a - c0, 6);
        chk(split - s0, 0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'h1;
        t_regs();
        t_clock();
        run(16'h0140, 1'h0, SRR_FMT_TS, 3, 1'h0, 3);
        run(16'h0180, 1'h0, SRR_FMT_TS, 3, 1'h1, 3);
        run(16'h4100, 1'h1, SRR_FMT_TS, 3, 1'h0, 3);
        run(16'h8100, 1'h1, SRR_FMT_TS, 3, 1'h1, 3);
        run(16'h4180, 1'h1, SRR_FMT_TS, 3, 1'h0, 3);
        run(16'h0440, 1'h0, SRR_FMT_VIDEO, 3, 1'h0, 3);
        run(16'h0040, 1'h0, SRR_FMT_VIDEO, 3, 1'h0, 0);
        run(16'h4000, 1'h1, SRR_FMT_SAT, 3, 1'h0, 0);
        run(16'h0040, 1'h0, SRR_FMT_TS, 3, 1'h0, 0);
        run(16'h0740, 1'h0, SRR_FMT_OTHER, 3, 1'h0, 0);
        run(16'h0248, 1'h0, SRR_FMT_SAT, 12, 1'h0, 2);
        run(16'h8a00, 1'h1, SRR_FMT_SAT, 12, 1'h1, 2);
        run(16'h0101, 1'h1, SRR_FMT_TS, 3, 1'h0, 3);
        run(16'h0103, 1'h0, SRR_FMT_TS, 3, 1'h1, 3);
        t_irq();
        t_merge();
        end_of_test();
    end
endmodule
